/* File: lfoe_pkg.sv */
/*
  constants of the layer fetch and output enable block.
  assumes a single 25 MHz system clock shared with the AHB slaves.
*/
// Contract
// - writing one to pixel clock enable starts the pixel clock unit; zero does nothing
// - writing one to sync enable starts horizontal and vertical sync; zero does nothing; the sync counters here advance only while pixel clock enable is set
// - writing one to display signal enable drives panel display-on; zero does nothing
// - writing one to backlight pwm enable starts the pwm generator; zero does nothing
// - source select zero fetches over AHB master 0, one over AHB master 1
// - burst setting 0 starts once one word fits; SINGLE, INCR and INCR4/8/16 allowed
// - burst setting 1 waits for four free words; INCR4, SINGLE, INCR used
// - burst setting 2 waits for eight free words; INCR8, SINGLE, INCR, INCR4 used
// - burst setting 3 waits for sixteen free words; INCR16 and all shorter used
// - defined length only zero allows INCR for 2-3 beats; one forbids INCR
// - rotation optimization active while its disable bit is zero, off when one
// - rotated fetch asserts AHB lock unless the lock disable bit is one
`default_nettype none
package lfoe_pkg;
  localparam logic [8:0] off_enable = 9'h020;
  localparam logic [8:0] off_disable = 9'h024;
  localparam logic [8:0] off_status = 9'h028;
  localparam logic [8:0] off_fetch_config = 9'h16c;
  localparam logic [8:0] off_fetch_base = 9'h170;
  localparam logic [8:0] off_fetch_words = 9'h174;
  localparam logic [8:0] off_fetch_control = 9'h178;
  localparam int pos_pixel_clock_enable = 0;
  localparam int pos_sync_generation_enable = 1;
  localparam int pos_display_signal_enable = 2;
  localparam int pos_backlight_pwm_enable = 3;
  localparam int pos_source_interface_select = 0;
  localparam int pos_burst_length_setting = 4;
  localparam int pos_defined_length_only = 8;
  localparam int pos_rotation_optimization_disable = 12;
  localparam int pos_rotation_lock_disable = 13;
  localparam int pos_rotate_fetch = 0;
  localparam int pos_fetch_busy = 4;
  localparam int pos_fifo_level = 8;
  localparam logic [31:0] reset_fetch_config = 32'h0000_0000;
  localparam logic [31:0] reset_fetch_base = 32'h0000_0000;
  localparam logic [15:0] reset_fetch_words = 16'h0000;
  localparam logic [1:0] burst_policy_one_word = 2'h0;
  localparam logic [1:0] burst_policy_four_words = 2'h1;
  localparam logic [1:0] burst_policy_eight_words = 2'h2;
  localparam logic [1:0] burst_policy_sixteen_words = 2'h3;
  localparam logic [1:0] htrans_idle = 2'h0;
  localparam logic [1:0] htrans_nonseq = 2'h2;
  localparam logic [1:0] htrans_seq = 2'h3;
  localparam logic [2:0] hburst_single = 3'h0;
  localparam logic [2:0] hburst_incr = 3'h1;
  localparam logic [2:0] hburst_incr4 = 3'h3;
  localparam logic [2:0] hburst_incr8 = 3'h5;
  localparam logic [2:0] hburst_incr16 = 3'h7;
  localparam int fifo_depth = 16;
  localparam logic [7:0] pixel_divide = 8'h02;
  localparam logic [15:0] line_total = 16'h0320;
  localparam logic [15:0] hsync_width = 16'h0060;
  localparam logic [15:0] frame_lines = 16'h020d;
  localparam logic [15:0] vsync_width = 16'h0002;
  localparam logic [7:0] pwm_duty = 8'h80;
  typedef enum logic [1:0] {
    lfoe_idle = 2'b00,
    lfoe_addr = 2'b01,
    lfoe_data = 2'b11
  } lfoe_state_t;
endpackage : lfoe_pkg
`default_nettype wire

/* File: lfoe_pair_buffer.sv */
/*
  two-entry buffer with valid and ready on both sides.
  assumes both sides run on the same clock; outputs are registered.
*/
`timescale 1ns/1ps
`default_nettype none
module lfoe_pair_buffer #(
  parameter int unsigned width = 32
) (
  input wire logic clock, // system clock
  input wire logic rst, // async reset, active high
  input wire logic [width-1:0] in_data, // word offered
  input wire logic in_valid, // word offered is valid
  output logic in_ready, // room for a word
  output logic [width-1:0] out_data, // oldest word
  output logic out_valid, // oldest word is valid
  input wire logic out_ready // receiver takes the word
);
  logic [width-1:0] slot1;
  logic [1:0] count;
  logic [1:0] next_count;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign next_count = 2'(count + {1'b0, push} - {1'b0, pop});

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count <= 2'h0;
      out_valid <= 1'b0;
      in_ready <= 1'b0;
    end else begin
      count <= next_count;
      out_valid <= (next_count != 2'h0);
      // ready falls only when both slots hold words, so a stall loses nothing
      in_ready <= (next_count != 2'h2);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      out_data <= '0;
      slot1 <= '0;
    end else if (push && pop) begin
      if (count == 2'h1) begin
        out_data <= in_data;
      end else begin
        out_data <= slot1;
        slot1 <= in_data;
      end
    end else if (pop) begin
      out_data <= slot1;
    end else if (push) begin
      if (count == 2'h0) begin
        out_data <= in_data;
      end else begin
        slot1 <= in_data;
      end
    end
  end
endmodule : lfoe_pair_buffer
`default_nettype wire

/* File: lfoe_core.sv */
/*
  display output enables and layer fetch engine with Avalon-MM registers.
  assumes the AHB slaves, the panel and the register master share the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module lfoe_core (
  input wire logic clock, // system clock, 25 MHz
  input wire logic rst, // async reset, active high
  input wire logic [8:0] address, // avalon byte address
  input wire logic read, // avalon read
  input wire logic write, // avalon write
  input wire logic [31:0] writedata, // avalon write data
  input wire logic [3:0] byteenable, // avalon byte lanes
  output logic [31:0] readdata, // avalon read data
  output logic waitrequest, // avalon wait
  output logic pixel_clock_out, // divided pixel clock level
  output logic horizontal_sync_out, // line sync
  output logic vertical_sync_out, // frame sync
  output logic panel_display_on_out, // panel display-on
  output logic backlight_pwm_out, // backlight pwm
  output logic [1:0] h0_htrans, // ahb master 0 transfer type
  output logic [31:0] h0_haddr, // ahb master 0 address
  output logic [2:0] h0_hburst, // ahb master 0 burst
  output logic h0_hlock, // ahb master 0 lock
  input wire logic h0_hready, // ahb master 0 ready
  input wire logic [31:0] h0_hrdata, // ahb master 0 read data
  output logic [1:0] h1_htrans, // ahb master 1 transfer type
  output logic [31:0] h1_haddr, // ahb master 1 address
  output logic [2:0] h1_hburst, // ahb master 1 burst
  output logic h1_hlock, // ahb master 1 lock
  input wire logic h1_hready, // ahb master 1 ready
  input wire logic [31:0] h1_hrdata, // ahb master 1 read data
  output logic [31:0] pixel_data, // fetched word
  output logic pixel_valid, // fetched word valid
  input wire logic pixel_ready // consumer takes the word
);
  logic [31:0] wmask;
  logic bus_write;
  logic bus_read;
  logic [31:0] enable_strobe;
  logic [31:0] disable_strobe;
  logic pixel_clock_enable;
  logic sync_generation_enable;
  logic display_signal_enable;
  logic backlight_pwm_enable;
  logic [31:0] overlay_one_fetch_config;
  logic [31:0] fetch_base;
  logic [15:0] fetch_words;
  logic rotate_fetch;
  logic source_interface_select;
  logic [1:0] burst_length_setting;
  logic defined_length_only;
  logic rotation_optimization_disable;
  logic rotation_lock_disable;

  assign wmask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}},
                  {8{byteenable[0]}}};
  // the write lands at the edge where the master sees waitrequest low
  assign bus_write = write && !waitrequest;
  assign bus_read = read && waitrequest;
  assign enable_strobe = (bus_write && address == lfoe_pkg::off_enable) ?
                         (writedata & wmask) : 32'h0;
  assign disable_strobe = (bus_write && address == lfoe_pkg::off_disable) ?
                          (writedata & wmask) : 32'h0;
  assign source_interface_select =
    overlay_one_fetch_config[lfoe_pkg::pos_source_interface_select];
  assign burst_length_setting =
    overlay_one_fetch_config[lfoe_pkg::pos_burst_length_setting +: 2];
  assign defined_length_only =
    overlay_one_fetch_config[lfoe_pkg::pos_defined_length_only];
  assign rotation_optimization_disable =
    overlay_one_fetch_config[lfoe_pkg::pos_rotation_optimization_disable];
  assign rotation_lock_disable =
    overlay_one_fetch_config[lfoe_pkg::pos_rotation_lock_disable];

  // one wait cycle, then one cycle with waitrequest low
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      waitrequest <= 1'b1;
    end else if ((read || write) && waitrequest) begin
      waitrequest <= 1'b0;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  // enables set on a one and clear only through the separate disable word
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pixel_clock_enable <= 1'b0;
      sync_generation_enable <= 1'b0;
      display_signal_enable <= 1'b0;
      backlight_pwm_enable <= 1'b0;
    end else begin
      if (enable_strobe[lfoe_pkg::pos_pixel_clock_enable]) begin
        pixel_clock_enable <= 1'b1;
      end else if (disable_strobe[lfoe_pkg::pos_pixel_clock_enable]) begin
        pixel_clock_enable <= 1'b0;
      end
      if (enable_strobe[lfoe_pkg::pos_sync_generation_enable]) begin
        sync_generation_enable <= 1'b1;
      end else if (disable_strobe[lfoe_pkg::pos_sync_generation_enable]) begin
        sync_generation_enable <= 1'b0;
      end
      if (enable_strobe[lfoe_pkg::pos_display_signal_enable]) begin
        display_signal_enable <= 1'b1;
      end else if (disable_strobe[lfoe_pkg::pos_display_signal_enable]) begin
        display_signal_enable <= 1'b0;
      end
      if (enable_strobe[lfoe_pkg::pos_backlight_pwm_enable]) begin
        backlight_pwm_enable <= 1'b1;
      end else if (disable_strobe[lfoe_pkg::pos_backlight_pwm_enable]) begin
        backlight_pwm_enable <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      overlay_one_fetch_config <= lfoe_pkg::reset_fetch_config;
      fetch_base <= lfoe_pkg::reset_fetch_base;
      fetch_words <= lfoe_pkg::reset_fetch_words;
      rotate_fetch <= 1'b0;
    end else if (bus_write) begin
      if (address == lfoe_pkg::off_fetch_config) begin
        overlay_one_fetch_config <= ((overlay_one_fetch_config & ~wmask) |
                                     (writedata & wmask)) & 32'h0000_3131;
      end else if (address == lfoe_pkg::off_fetch_base) begin
        fetch_base <= ((fetch_base & ~wmask) | (writedata & wmask)) & 32'hffff_fffc;
      end else if (address == lfoe_pkg::off_fetch_words) begin
        fetch_words <= (fetch_words & ~wmask[15:0]) | (writedata[15:0] & wmask[15:0]);
      end else if (address == lfoe_pkg::off_fetch_control && byteenable[0]) begin
        rotate_fetch <= writedata[lfoe_pkg::pos_rotate_fetch];
      end
    end
  end

  // pixel clock, sync and pwm generation
  logic [7:0] pix_div;
  logic pix_tick;
  logic [15:0] h_count;
  logic [15:0] v_count;
  logic [7:0] pwm_count;

  assign pix_tick = pixel_clock_enable && (pix_div == 8'(lfoe_pkg::pixel_divide - 8'h01));

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pix_div <= 8'h00;
      pixel_clock_out <= 1'b0;
    end else if (!pixel_clock_enable) begin
      pix_div <= 8'h00;
      pixel_clock_out <= 1'b0;
    end else begin
      pix_div <= pix_tick ? 8'h00 : 8'(pix_div + 8'h01);
      if (pix_tick) begin
        pixel_clock_out <= !pixel_clock_out;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      h_count <= 16'h0000;
      v_count <= 16'h0000;
      horizontal_sync_out <= 1'b0;
      vertical_sync_out <= 1'b0;
    end else if (!sync_generation_enable) begin
      h_count <= 16'h0000;
      v_count <= 16'h0000;
      horizontal_sync_out <= 1'b0;
      vertical_sync_out <= 1'b0;
    end else if (pix_tick) begin
      if (h_count == 16'(lfoe_pkg::line_total - 16'h0001)) begin
        h_count <= 16'h0000;
        v_count <= (v_count == 16'(lfoe_pkg::frame_lines - 16'h0001)) ? 16'h0000 :
                   16'(v_count + 16'h0001);
      end else begin
        h_count <= 16'(h_count + 16'h0001);
      end
      horizontal_sync_out <= (h_count < lfoe_pkg::hsync_width);
      vertical_sync_out <= (v_count < lfoe_pkg::vsync_width);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      panel_display_on_out <= 1'b0;
      pwm_count <= 8'h00;
      backlight_pwm_out <= 1'b0;
    end else begin
      panel_display_on_out <= display_signal_enable;
      pwm_count <= backlight_pwm_enable ? 8'(pwm_count + 8'h01) : 8'h00;
      backlight_pwm_out <= backlight_pwm_enable && (pwm_count < lfoe_pkg::pwm_duty);
    end
  end

  // fetch fifo and burst engine
  logic [31:0] fifo_mem [lfoe_pkg::fifo_depth];
  logic [3:0] fifo_wr;
  logic [3:0] fifo_rd;
  logic [4:0] fifo_count;
  logic [4:0] fifo_free;
  logic fifo_push;
  logic fifo_pop;
  logic buf_ready;
  lfoe_pkg::lfoe_state_t state;
  logic bus_sel;
  logic [1:0] htrans;
  logic [31:0] haddr;
  logic to_h1;
  logic data_phase;
  logic [4:0] addr_left;
  logic [4:0] data_left;
  logic [31:0] fetch_addr;
  logic [15:0] words_left;
  logic sel_hready;
  logic [31:0] sel_hrdata;
  logic [4:0] threshold;
  logic [4:0] max_burst;
  logic [4:0] cap;
  logic [4:0] beats;
  logic [2:0] burst_code;
  logic start;

  assign fifo_free = 5'(5'd16 - fifo_count);
  assign sel_hready = bus_sel ? h1_hready : h0_hready;
  assign sel_hrdata = bus_sel ? h1_hrdata : h0_hrdata;
  assign fifo_push = (state != lfoe_pkg::lfoe_idle) && sel_hready && data_phase;
  assign fifo_pop = (fifo_count != 5'h00) && buf_ready;
  assign to_h1 = source_interface_select;
  assign htrans = bus_sel ? h1_htrans : h0_htrans;
  assign haddr = bus_sel ? h1_haddr : h0_haddr;

  always_comb begin
    case (burst_length_setting)
      lfoe_pkg::burst_policy_four_words: threshold = 5'd4;
      lfoe_pkg::burst_policy_eight_words: threshold = 5'd8;
      lfoe_pkg::burst_policy_sixteen_words: threshold = 5'd16;
      default: threshold = 5'd1;
    endcase
    max_burst = (burst_length_setting == lfoe_pkg::burst_policy_one_word) ? 5'd16 :
                threshold;
    cap = fifo_free;
    if ({11'h000, cap} > words_left) begin
      cap = words_left[4:0];
    end
    if (cap > max_burst) begin
      cap = max_burst;
    end
    // without the optimization a rotated layer is read one word per access
    if (rotate_fetch && rotation_optimization_disable) begin
      cap = 5'd1;
    end
    if (cap >= 5'd16) begin
      beats = 5'd16;
      burst_code = lfoe_pkg::hburst_incr16;
    end else if (cap >= 5'd8) begin
      beats = 5'd8;
      burst_code = lfoe_pkg::hburst_incr8;
    end else if (cap >= 5'd4) begin
      beats = 5'd4;
      burst_code = lfoe_pkg::hburst_incr4;
    end else if (cap >= 5'd2 && !defined_length_only) begin
      beats = cap;
      burst_code = lfoe_pkg::hburst_incr;
    end else begin
      beats = 5'd1;
      burst_code = lfoe_pkg::hburst_single;
    end
  end

  // a short tail below the threshold still goes once it fits entirely
  assign start = (state == lfoe_pkg::lfoe_idle) && pixel_clock_enable &&
                 (words_left != 16'h0000) && (cap != 5'h00) &&
                 ((fifo_free >= threshold) || ({11'h000, fifo_free} >= words_left));

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= lfoe_pkg::lfoe_idle;
      bus_sel <= 1'b0;
      h0_htrans <= lfoe_pkg::htrans_idle;
      h1_htrans <= lfoe_pkg::htrans_idle;
      h0_haddr <= 32'h0;
      h1_haddr <= 32'h0;
      h0_hburst <= lfoe_pkg::hburst_single;
      h1_hburst <= lfoe_pkg::hburst_single;
      h0_hlock <= 1'b0;
      h1_hlock <= 1'b0;
      data_phase <= 1'b0;
      addr_left <= 5'h00;
      data_left <= 5'h00;
      fetch_addr <= 32'h0;
      words_left <= 16'h0000;
    end else if (start) begin
      state <= lfoe_pkg::lfoe_addr;
      bus_sel <= source_interface_select;
      // unselected master stays idle
      h0_htrans <= to_h1 ? lfoe_pkg::htrans_idle : lfoe_pkg::htrans_nonseq;
      h1_htrans <= to_h1 ? lfoe_pkg::htrans_nonseq : lfoe_pkg::htrans_idle;
      h0_haddr <= to_h1 ? 32'h0 : fetch_addr;
      h1_haddr <= to_h1 ? fetch_addr : 32'h0;
      h0_hburst <= to_h1 ? lfoe_pkg::hburst_single : burst_code;
      h1_hburst <= to_h1 ? burst_code : lfoe_pkg::hburst_single;
      h0_hlock <= !to_h1 && rotate_fetch && !rotation_lock_disable;
      h1_hlock <= to_h1 && rotate_fetch && !rotation_lock_disable;
      addr_left <= beats;
      data_left <= beats;
      data_phase <= 1'b0;
      fetch_addr <= fetch_addr + {25'h0, beats, 2'b00};
      words_left <= 16'(words_left - {11'h000, beats});
    end else if (state == lfoe_pkg::lfoe_idle) begin
      if (!pixel_clock_enable || words_left == 16'h0000) begin
        // a new frame restarts from the programmed base
        fetch_addr <= fetch_base;
        words_left <= pixel_clock_enable ? fetch_words : 16'h0000;
      end
    end else if (sel_hready) begin
      data_phase <= (htrans != lfoe_pkg::htrans_idle);
      if (htrans != lfoe_pkg::htrans_idle) begin
        addr_left <= 5'(addr_left - 5'h01);
        if (addr_left > 5'h01 && bus_sel) begin
          h1_htrans <= lfoe_pkg::htrans_seq;
          h1_haddr <= haddr + 32'h4;
        end else if (addr_left > 5'h01) begin
          h0_htrans <= lfoe_pkg::htrans_seq;
          h0_haddr <= haddr + 32'h4;
        end else begin
          h0_htrans <= lfoe_pkg::htrans_idle;
          h1_htrans <= lfoe_pkg::htrans_idle;
          state <= lfoe_pkg::lfoe_data;
        end
      end
      if (data_phase) begin
        data_left <= 5'(data_left - 5'h01);
        if (data_left == 5'h01) begin
          state <= lfoe_pkg::lfoe_idle;
          h0_hlock <= 1'b0;
          h1_hlock <= 1'b0;
          data_phase <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (fifo_push) begin
      fifo_mem[fifo_wr] <= sel_hrdata;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fifo_wr <= 4'h0;
      fifo_rd <= 4'h0;
      fifo_count <= 5'h00;
    end else begin
      if (fifo_push) begin
        fifo_wr <= 4'(fifo_wr + 4'h1);
      end
      if (fifo_pop) begin
        fifo_rd <= 4'(fifo_rd + 4'h1);
      end
      fifo_count <= 5'(fifo_count + {4'h0, fifo_push} - {4'h0, fifo_pop});
    end
  end

  lfoe_pair_buffer #(
    .width(32)
  ) u_out_buffer (
    .clock(clock),
    .rst(rst),
    .in_data(fifo_mem[fifo_rd]),
    .in_valid(fifo_count != 5'h00),
    .in_ready(buf_ready),
    .out_data(pixel_data),
    .out_valid(pixel_valid),
    .out_ready(pixel_ready)
  );

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      readdata <= 32'h0;
    end else if (bus_read) begin
      if (address == lfoe_pkg::off_status) begin
        readdata <= {19'h0, fifo_count, 3'h0, (state != lfoe_pkg::lfoe_idle),
                     backlight_pwm_enable, display_signal_enable,
                     sync_generation_enable, pixel_clock_enable};
      end else if (address == lfoe_pkg::off_fetch_config) begin
        readdata <= overlay_one_fetch_config;
      end else if (address == lfoe_pkg::off_fetch_base) begin
        readdata <= fetch_base;
      end else if (address == lfoe_pkg::off_fetch_words) begin
        readdata <= {16'h0, fetch_words};
      end else if (address == lfoe_pkg::off_fetch_control) begin
        readdata <= {31'h0, rotate_fetch};
      end else begin
        readdata <= 32'h0;
      end
    end
  end
endmodule : lfoe_core
`default_nettype wire

/* File: lfoe_ahb_slave.sv */
/*
  ahb slave model for one master port: answers each beat with address xor key.
  assumes the shared system clock; stall comes from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module lfoe_ahb_slave #(
  parameter logic [31:0] key = 32'h0
) (
  input wire logic clock, // clk
  input wire logic rst, // reset
  input wire logic [1:0] htrans, // trans
  input wire logic [31:0] haddr, // addr
  input wire logic stall, // wait state
  output logic hready, // ready
  output logic [31:0] hrdata // data
);
  logic ph;
  logic [31:0] pa;
  logic [31:0] seen;
  assign hready = !stall;
  // off a data beat show the inverse of the last word
  assign hrdata = (ph && hready) ? (pa ^ key) : ~seen;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ph <= 1'b0;
      pa <= 32'h0;
      seen <= 32'h0;
    end else if (hready) begin
      ph <= htrans[1];
      pa <= haddr;
      seen <= hrdata;
    end
  end
endmodule : lfoe_ahb_slave
`default_nettype wire

/* File: lfoe_core_assertions.sv */
/*
  port checker for lfoe_core, bound into every instance.
  assumes the fetch setup is written only while no fetch runs.
*/
`timescale 1ns/1ps
`default_nettype none
module lfoe_core_assertions (
  input wire logic clock, // clk
  input wire logic rst, // reset
  input wire logic [8:0] address, // addr
  input wire logic write, // wr
  input wire logic [31:0] writedata, // wdata
  input wire logic waitrequest, // wait
  input wire logic pixel_clock_out, // pclk
  input wire logic panel_display_on_out, // disp
  input wire logic [1:0] h0_htrans, // trans 0
  input wire logic [2:0] h0_hburst, // burst 0
  input wire logic h0_hlock, // lock 0
  input wire logic [1:0] h1_htrans, // trans 1
  input wire logic [2:0] h1_hburst, // burst 1
  input wire logic h1_hlock // lock 1
);
  logic [31:0] cfg;
  logic rot;
  logic wr_ok;
  logic ew;
  logic ns;
  logic act;
  logic [2:0] bs;
  assign wr_ok = write && !waitrequest;
  assign ew = wr_ok && address == lfoe_pkg::off_enable;
  assign ns = h0_htrans == lfoe_pkg::htrans_nonseq || h1_htrans == lfoe_pkg::htrans_nonseq;
  assign act = h0_htrans[1] || h1_htrans[1];
  // the idle master shows SINGLE, zero
  assign bs = h0_hburst | h1_hburst;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg <= 32'h0;
      rot <= 1'b0;
    end else if (wr_ok && address == lfoe_pkg::off_fetch_config) begin
      cfg <= writedata;
    end else if (wr_ok && address == lfoe_pkg::off_fetch_control) begin
      rot <= writedata[0];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_clk_on; ew && writedata[0] |-> ##[1:6] pixel_clock_out; endproperty
  a_clk_on: assert property (p_clk_on) else $error("pixel clock idle");
  property p_disp_on; ew && writedata[2] |-> ##[1:2] panel_display_on_out; endproperty
  a_disp_on: assert property (p_disp_on) else $error("display not on");
  property p_disp_keep; ew && !writedata[2] && panel_display_on_out |=> panel_display_on_out[*2];
  endproperty
  a_disp_keep: assert property (p_disp_keep) else $error("display dropped");
  property p_sif; act |-> h1_htrans[1] == cfg[0] && !(h0_htrans[1] && h1_htrans[1]); endproperty
  a_sif: assert property (p_sif) else $error("wrong master");
  property p_burst_length_setting; ns |-> !(cfg[5:4] == 2'h1 && bs > 3'h3) && !(cfg[5:4] == 2'h2 && bs > 3'h5);
  endproperty
  a_burst_length_setting: assert property (p_burst_length_setting) else $error("burst too long");
  property p_defined_length_only; ns && cfg[8] |-> bs != lfoe_pkg::hburst_incr; endproperty
  a_defined_length_only: assert property (p_defined_length_only) else $error("undefined burst");
  property p_rotation_optimization_disable; ns && rot && cfg[12] |-> bs == lfoe_pkg::hburst_single; endproperty
  a_rotation_optimization_disable: assert property (p_rotation_optimization_disable) else $error("burst while rotated");
  property p_lock; act |-> (h0_hlock || h1_hlock) == (rot && !cfg[13]); endproperty
  a_lock: assert property (p_lock) else $error("lock wrong");
  c_lock: cover property (act && (h0_hlock || h1_hlock));
  c_h1: cover property (h1_htrans == lfoe_pkg::htrans_nonseq);
  c_incr16: cover property (ns && bs == lfoe_pkg::hburst_incr16);
endmodule : lfoe_core_assertions
bind lfoe_core lfoe_core_assertions u_chk (.clock, .rst, .address, .write, .writedata,
  .waitrequest, .pixel_clock_out, .panel_display_on_out, .h0_htrans, .h0_hburst, .h0_hlock,
  .h1_htrans, .h1_hburst, .h1_hlock);
`default_nettype wire

/* File: lfoe_core_test.sv */
/*
  self-checking bench for lfoe_core: enables, registers, fetch stream.
  assumes two lfoe_ahb_slave models; stream expected from base, count and key.
*/
`timescale 1ns/1ps
`default_nettype none
module lfoe_core_test;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [8:0] address = 9'h0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, pixel_data, h0_haddr, h1_haddr, h0_hrdata, h1_hrdata, q, c;
  logic waitrequest, pco, hso, vso, pdo, bpo, h0_hlock, h1_hlock, h0_hready, h1_hready;
  logic pixel_valid, r;
  logic [1:0] h0_htrans, h1_htrans;
  logic [2:0] h0_hburst, h1_hburst;
  logic pixel_ready = 1'b1, st0 = 1'b0, st1 = 1'b0, chk_on = 1'b0, seen_lock = 1'b0;
  logic [3:0] seen;
  logic [31:0] base = 32'h0, key = 32'h0;
  int num_errors = 0, comparisons = 0, cyc = 0, idx = 0, cnt = 1;
  always #20 clock = ~clock;
  lfoe_core u_dut (.clock, .rst, .address, .read, .write, .writedata, .byteenable(4'hf),
    .readdata, .waitrequest, .pixel_clock_out(pco), .horizontal_sync_out(hso),
    .vertical_sync_out(vso), .panel_display_on_out(pdo), .backlight_pwm_out(bpo),
    .h0_htrans, .h0_haddr, .h0_hburst, .h0_hlock, .h0_hready, .h0_hrdata, .h1_htrans,
    .h1_haddr, .h1_hburst, .h1_hlock, .h1_hready, .h1_hrdata, .pixel_data, .pixel_valid,
    .pixel_ready);
  lfoe_ahb_slave #(.key(32'h0f0f0000)) u_s0 (.clock, .rst, .htrans(h0_htrans),
    .haddr(h0_haddr), .stall(st0), .hready(h0_hready), .hrdata(h0_hrdata));
  lfoe_ahb_slave #(.key(32'hf0f00000)) u_s1 (.clock, .rst, .htrans(h1_htrans),
    .haddr(h1_haddr), .stall(st1), .hready(h1_hready), .hrdata(h1_hrdata));
  task stop_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] g, e);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task bus(input logic w, input logic [8:0] a, input logic [31:0] d);
    @(posedge clock);
    write <= w;
    read <= !w;
    address <= a;
    writedata <= d;
    do @(posedge clock); while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask : bus
  task do_reset;
    rst <= 1'b1;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
  endtask : do_reset
  always @(posedge clock) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      stop_test();
    end
    seen_lock <= chk_on && (seen_lock || h0_hlock === 1'b1 || h1_hlock === 1'b1);
    if (chk_on && pixel_valid === 1'b1 && pixel_ready === 1'b1) begin
      chk(pixel_data, (base + 32'(4 * (idx % cnt))) ^ key);
      idx++;
    end
    // random stalls fill the buffer
    pixel_ready <= $urandom % 4 != 0;
    st0 <= $urandom % 3 == 0;
    st1 <= $urandom % 3 == 0;
  end
  initial begin
    void'($urandom(32'h82aba9ac));
    do_reset();
    bus(1'b1, lfoe_pkg::off_enable, 32'hf);
    repeat (2) @(posedge clock);
    chk({31'h0, pdo}, 32'h1);
    bus(1'b1, lfoe_pkg::off_enable, 32'h0);
    seen = 4'h0;
    repeat (3400) begin
      @(posedge clock);
      seen = seen | {bpo, vso, hso, pco};
    end
    chk({28'h0, seen}, 32'hf);
    chk({31'h0, pdo}, 32'h1);
    bus(1'b0, lfoe_pkg::off_status, 32'h0);
    chk(q & 32'hf, 32'hf);
    bus(1'b0, lfoe_pkg::off_fetch_config, 32'h0);
    chk(q, lfoe_pkg::reset_fetch_config);
    bus(1'b1, lfoe_pkg::off_fetch_config, 32'hffffffff);
    bus(1'b0, lfoe_pkg::off_fetch_config, 32'h0);
    chk(q, 32'h3131);
    bus(1'b0, lfoe_pkg::off_enable, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 9'h1fc, 32'hffffffff);
    bus(1'b0, 9'h1fc, 32'h0);
    chk(q, 32'h0);
    for (int k = 0; k < 8; k++) begin
      do_reset();
      c = ($urandom & 32'h3100) | 32'((k % 4) << 4) | 32'(k / 4);
      base = $urandom & 32'hfffffffc;
      cnt = 2 + $urandom % 19;
      key = (k / 4 == 1) ? 32'hf0f00000 : 32'h0f0f0000;
      r = 1'($urandom);
      bus(1'b1, lfoe_pkg::off_fetch_config, c);
      bus(1'b1, lfoe_pkg::off_fetch_base, base);
      bus(1'b1, lfoe_pkg::off_fetch_words, 32'(cnt));
      bus(1'b1, lfoe_pkg::off_fetch_control, {31'h0, r});
      idx = 0;
      chk_on = 1'b1;
      bus(1'b1, lfoe_pkg::off_enable, 32'h1);
      wait (idx >= 24);
      chk_on = 1'b0;
      chk({31'h0, seen_lock}, {31'h0, r & !c[13]});
    end
    stop_test();
  end
endmodule : lfoe_core_test
`default_nettype wire
